// ==== eicu_regs.svh ====
// register offsets, field positions and reset values of the edge interrupt context unit
`ifndef EICU_REGS_SVH
`define EICU_REGS_SVH
// ============================================================
// register offsets (12-bit byte address)
`define EICU_OFS_CTRL 12'h000
`define EICU_OFS_OPT 12'h001
`define EICU_OFS_RISE 12'h002
`define EICU_OFS_FALL 12'h003
`define EICU_OFS_FLAGS 12'h004
`define EICU_OFS_SHADOW 12'hf80
`define EICU_SHADOW_CNT 8
// ============================================================
// control and option register fields
`define EICU_CTRL_GIE 7
`define EICU_CTRL_EXT_IRQ_ENABLE 4
`define EICU_CTRL_IOCIE 3
`define EICU_CTRL_EXT_IRQ_FLAG 1
`define EICU_OPT_EDGE 6
// ============================================================
// reset values
`define EICU_RST_CTRL 8'h00
`define EICU_RST_OPT 8'h40
`define EICU_RST_CHANGE 6'h00
// arithmetic status bits kept by the shadow copy (zero, digit carry, carry)
`define EICU_STATUS_KEEP 8'h07
`define EICU_SLOT_STATUS 1
`endif

// ==== eicu_pkg.sv ====
// types shared by the edge interrupt context unit
package eicu_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } eicu_bus_req_t;

   // core context saved on entry; slot order matches the shadow offsets
   typedef struct packed {
      logic [7:0] pc_high_latch;
      logic [7:0] fsr1h;
      logic [7:0] fsr1l;
      logic [7:0] fsr0h;
      logic [7:0] fsr0l;
      logic [7:0] bank_select_reg;
      logic [7:0] status;
      logic [7:0] w;
   } eicu_ctx_t;

   typedef enum logic [3:0] {
      EICU_RUN = 4'b0001,
      EICU_WAKE_STEP = 4'b0010,
      EICU_ENTER = 4'b0100,
      EICU_IN_ISR = 4'b1000
   } eicu_state_t;
endpackage

// ==== eicu_shadow_mem.sv ====
// shadow register store: software port plus whole-context capture
`timescale 1ns/1ps
`include "eicu_regs.svh"
module eicu_shadow_mem #(
   parameter int ENTRIES = `EICU_SHADOW_CNT
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sw_we,
   input wire logic [2:0] sw_idx,
   input wire logic [7:0] sw_wdata,
   input wire logic capture,
   input wire eicu_pkg::eicu_ctx_t ctx_in,
   output eicu_pkg::eicu_ctx_t ctx_out
);
   import eicu_pkg::*;
   logic [ENTRIES*8-1:0] store_r;

   // ============================================================
   // storage; capture wins over a software write in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < ENTRIES; gi++) begin : g_slot
         logic [7:0] keep;
         assign keep = (gi == `EICU_SLOT_STATUS) ? `EICU_STATUS_KEEP : 8'hff;
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               store_r[gi*8 +: 8] <= 8'h00;
            end else if (capture) begin
               store_r[gi*8 +: 8] <= ctx_in[gi*8 +: 8] & keep;
            end else if (sw_we && sw_idx == 3'(gi)) begin
               store_r[gi*8 +: 8] <= sw_wdata & keep;
            end
         end
      end
   endgenerate

   assign ctx_out = store_r;
endmodule // eicu_shadow_mem

// ==== eicu_top.sv ====
// edge interrupt context unit: pin edges, change detect, wake and context shadowing
//
// Overview of operation
// - external pin edge requests interrupt when enabled
// - polarity bit selects rising or falling edge
// - selected edge sets external pin flag
// - flag with both enables vectors the core
// - wake vectors if global enable, else continues
// - one instruction after sleep runs first
// - entry pushes return address on stack
// - entry copies context into shadow registers
// - return restores all shadowed registers
// - shadows are software accessible and restored
// - rise enables arm rising detection, bits 7-6 zero
// - fall enables arm falling detection per pin
// - enabled edge sets that pin's change flag
// - change flags stay until software clears
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "eicu_regs.svh"
module eicu_top #(
   parameter int PINS = 6
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire eicu_pkg::eicu_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   input wire logic ext_pin,
   input wire logic [PINS-1:0] port_pin_n,
   input wire logic core_sleeping,
   input wire logic instr_done,
   input wire logic irq_return,
   input wire logic [12:0] return_pc,
   input wire eicu_pkg::eicu_ctx_t live_ctx,
   output logic wake_req,
   output logic irq_vector,
   output logic stack_push,
   output logic [12:0] stack_pc,
   output logic ctx_restore,
   output eicu_pkg::eicu_ctx_t restore_ctx
);
   import eicu_pkg::*;

   // ============================================================
   // reset release
   logic rst_meta_r;
   logic rst_n;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // ============================================================
   // pin synchronisers; edge detection looks only at the second stage
   logic [PINS:0] pin_meta_r;
   logic [PINS:0] pin_sync_r;
   logic [PINS:0] pin_prev_r;
   logic [PINS:0] rise;
   logic [PINS:0] fall;
   logic [2:0] pin_fill_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
         pin_prev_r <= '0;
         pin_fill_r <= 3'h0;
      end else begin
         pin_meta_r <= {ext_pin, port_pin_n};
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
         pin_fill_r <= {pin_fill_r[1:0], 1'b1};
      end
   end
   // edges count only once both stages hold real pin levels; a pin that idles high
   // would otherwise fake a rising edge right after reset
   assign rise = pin_fill_r[2] ? (pin_sync_r & ~pin_prev_r) : '0;
   assign fall = pin_fill_r[2] ? (~pin_sync_r & pin_prev_r) : '0;

   // ============================================================
   // register decode
   logic wr_ctrl;
   logic wr_opt;
   logic wr_rise;
   logic wr_fall;
   logic wr_flags;
   logic wr_shadow;
   logic [11:0] shadow_ofs;
   assign shadow_ofs = bus_req.addr - `EICU_OFS_SHADOW;
   assign wr_ctrl = bus_req.wr && bus_req.addr == `EICU_OFS_CTRL;
   assign wr_opt = bus_req.wr && bus_req.addr == `EICU_OFS_OPT;
   assign wr_rise = bus_req.wr && bus_req.addr == `EICU_OFS_RISE;
   assign wr_fall = bus_req.wr && bus_req.addr == `EICU_OFS_FALL;
   assign wr_flags = bus_req.wr && bus_req.addr == `EICU_OFS_FLAGS;
   assign wr_shadow = bus_req.wr && shadow_ofs < 12'(`EICU_SHADOW_CNT);

   // ============================================================
   // configuration registers
   logic ext_edge_polarity_r;
   logic ext_irq_enable_r;
   logic change_irq_enable_r;
   logic [PINS-1:0] change_rise_enable_r;
   logic [PINS-1:0] change_fall_enable_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_edge_polarity_r <= 1'(`EICU_RST_OPT >> `EICU_OPT_EDGE);
         ext_irq_enable_r <= 1'(`EICU_RST_CTRL >> `EICU_CTRL_EXT_IRQ_ENABLE);
         change_irq_enable_r <= 1'(`EICU_RST_CTRL >> `EICU_CTRL_IOCIE);
      end else begin
         if (wr_opt) begin
            ext_edge_polarity_r <= bus_req.wdata[`EICU_OPT_EDGE];
         end
         if (wr_ctrl) begin
            ext_irq_enable_r <= bus_req.wdata[`EICU_CTRL_EXT_IRQ_ENABLE];
            change_irq_enable_r <= bus_req.wdata[`EICU_CTRL_IOCIE];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         change_rise_enable_r <= PINS'(`EICU_RST_CHANGE);
         change_fall_enable_r <= PINS'(`EICU_RST_CHANGE);
      end else begin
         if (wr_rise) begin
            change_rise_enable_r <= bus_req.wdata[PINS-1:0];
         end
         if (wr_fall) begin
            change_fall_enable_r <= bus_req.wdata[PINS-1:0];
         end
      end
   end

   // ============================================================
   // external pin flag; a detected edge wins over a clearing write
   logic ext_irq_flag_r;
   logic ext_edge_hit;
   assign ext_edge_hit = ext_edge_polarity_r ? rise[PINS] : fall[PINS];
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_irq_flag_r <= 1'b0;
      end else if (ext_edge_hit) begin
         ext_irq_flag_r <= 1'b1;
      end else if (wr_ctrl) begin
         ext_irq_flag_r <= bus_req.wdata[`EICU_CTRL_EXT_IRQ_FLAG];
      end
   end

   // ============================================================
   // per-pin change flags
   logic [PINS-1:0] change_detect_flags_r;
   logic [PINS-1:0] change_hit;
   genvar gp;
   generate
      for (gp = 0; gp < PINS; gp++) begin : g_pin
         // either enabled direction may set the flag independently
         assign change_hit[gp] = (change_rise_enable_r[gp] & rise[gp]) |
                                 (change_fall_enable_r[gp] & fall[gp]);
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               change_detect_flags_r[gp] <= 1'b0;
            end else if (change_hit[gp]) begin
               change_detect_flags_r[gp] <= 1'b1;
            end else if (wr_flags) begin
               change_detect_flags_r[gp] <= bus_req.wdata[gp];
            end
         end
      end
   endgenerate

   // ============================================================
   // request and wake conditions
   logic global_irq_enable_r;
   logic source_active;
   logic irq_pending;
   // wake ignores the global enable so a sleeping core can resume inline
   assign source_active = (ext_irq_flag_r & ext_irq_enable_r) |
                          ((|change_detect_flags_r) & change_irq_enable_r);
   assign irq_pending = global_irq_enable_r & source_active;

   // ============================================================
   // core sequencer
   eicu_state_t state_r, state_nxt;
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         EICU_RUN: begin
            if (core_sleeping && source_active) begin
               state_nxt = EICU_WAKE_STEP;
            end else if (!core_sleeping && instr_done && irq_pending) begin
               state_nxt = EICU_ENTER;
            end
         end
         EICU_WAKE_STEP: begin
            // the instruction after sleep retires before any vectoring
            if (instr_done) begin
               state_nxt = irq_pending ? EICU_ENTER : EICU_RUN;
            end
         end
         EICU_ENTER: begin
            state_nxt = EICU_IN_ISR;
         end
         EICU_IN_ISR: begin
            if (irq_return) begin
               state_nxt = EICU_RUN;
            end
         end
         default: begin
            state_nxt = EICU_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= EICU_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // global enable: cleared on entry so the routine is not re-entered, set on return
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         global_irq_enable_r <= 1'(`EICU_RST_CTRL >> `EICU_CTRL_GIE);
      end else if (state_r == EICU_ENTER) begin
         global_irq_enable_r <= 1'b0;
      end else if (state_r == EICU_IN_ISR && irq_return) begin
         global_irq_enable_r <= 1'b1;
      end else if (wr_ctrl) begin
         global_irq_enable_r <= bus_req.wdata[`EICU_CTRL_GIE];
      end
   end

   // ============================================================
   // core-facing strobes and context transfer
   logic entering;
   assign entering = state_r == EICU_ENTER;
   assign wake_req = state_r == EICU_RUN && core_sleeping && source_active;
   assign irq_vector = entering;
   assign stack_push = entering;
   assign ctx_restore = state_r == EICU_IN_ISR && irq_return;

   // taken on the deciding edge so the pushed value belongs to the retiring instruction
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stack_pc <= 13'h0000;
      end else if (state_nxt == EICU_ENTER) begin
         stack_pc <= return_pc;
      end
   end

   eicu_shadow_mem #(
      .ENTRIES(`EICU_SHADOW_CNT)
   ) u_shadow (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sw_we(wr_shadow),
      .sw_idx(shadow_ofs[2:0]),
      .sw_wdata(bus_req.wdata),
      .capture(entering),
      .ctx_in(live_ctx),
      .ctx_out(restore_ctx)
   );

   // ============================================================
   // read port, data in the cycle after the strobe; unmapped reads zero
   logic [7:0] rdata_nxt;
   always_comb begin
      rdata_nxt = 8'h00;
      if (bus_req.addr == `EICU_OFS_CTRL) begin
         rdata_nxt[`EICU_CTRL_GIE] = global_irq_enable_r;
         rdata_nxt[`EICU_CTRL_EXT_IRQ_ENABLE] = ext_irq_enable_r;
         rdata_nxt[`EICU_CTRL_IOCIE] = change_irq_enable_r;
         rdata_nxt[`EICU_CTRL_EXT_IRQ_FLAG] = ext_irq_flag_r;
      end else if (bus_req.addr == `EICU_OFS_OPT) begin
         rdata_nxt[`EICU_OPT_EDGE] = ext_edge_polarity_r;
      end else if (bus_req.addr == `EICU_OFS_RISE) begin
         rdata_nxt[PINS-1:0] = change_rise_enable_r;
      end else if (bus_req.addr == `EICU_OFS_FALL) begin
         rdata_nxt[PINS-1:0] = change_fall_enable_r;
      end else if (bus_req.addr == `EICU_OFS_FLAGS) begin
         rdata_nxt[PINS-1:0] = change_detect_flags_r;
      end else if (shadow_ofs < 12'(`EICU_SHADOW_CNT)) begin
         rdata_nxt = restore_ctx[shadow_ofs[2:0]*8 +: 8];
      end
   end

   // zero outside the answer cycle so stale register contents never linger on the bus
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata <= 8'h00;
      end else if (bus_req.rd) begin
         bus_rdata <= rdata_nxt;
      end else begin
         bus_rdata <= 8'h00;
      end
   end
endmodule // eicu_top

// ==== eicu_top_monitor.sv ====
// concurrent checks on the ports of the edge interrupt context unit
`timescale 1ns/1ps
module eicu_top_monitor #(
   parameter int PINS = 6
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic core_sleeping,
   input wire logic instr_done,
   input wire logic irq_return,
   input wire logic [12:0] return_pc,
   input wire logic wake_req,
   input wire logic irq_vector,
   input wire logic stack_push,
   input wire logic [12:0] stack_pc,
   input wire logic ctx_restore,
   input wire eicu_pkg::eicu_ctx_t restore_ctx
);
   import eicu_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   // ============================================================
   // entry and exit
   sequence s_push_once;
      stack_push ##1 !stack_push;
   endsequence
   property p_push_vec;
      irq_vector |-> s_push_once;
   endproperty
   a_push_vec: assert property (p_push_vec) else $error("push missing at vector");
   property p_pc;
      stack_push |-> stack_pc == $past(return_pc);
   endproperty
   a_pc: assert property (p_pc) else $error("pushed pc wrong");
   property p_vec_done;
      irq_vector |-> $past(instr_done);
   endproperty
   a_vec_done: assert property (p_vec_done) else $error("vector without retire");
   property p_no_vec_sleep;
      core_sleeping |-> !irq_vector;
   endproperty
   a_no_vec_sleep: assert property (p_no_vec_sleep) else $error("vector in sleep");
   property p_wake;
      wake_req |-> core_sleeping ##1 !irq_vector;
   endproperty
   a_wake: assert property (p_wake) else $error("wake while awake");
   property p_restore;
      ctx_restore |-> irq_return;
   endproperty
   a_restore: assert property (p_restore) else $error("restore without return");
   property p_restore_pulse;
      ctx_restore |=> !ctx_restore;
   endproperty
   a_restore_pulse: assert property (p_restore_pulse) else $error("restore too long");
   property p_status_mask;
      ctx_restore |-> restore_ctx.status[7:3] == 5'h00;
   endproperty
   a_status_mask: assert property (p_status_mask) else $error("status mask");
endmodule // eicu_top_monitor
bind eicu_top eicu_top_monitor #(.PINS(PINS)) mon_u (.core_clk, .rst_b, .core_sleeping,
   .instr_done, .irq_return, .return_pc, .wake_req, .irq_vector, .stack_push,
   .stack_pc, .ctx_restore, .restore_ctx);

// ==== eicu_core_model.sv ====
// behavioural core sequencer that retires instructions and takes vectors
`timescale 1ns/1ps
module eicu_core_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic ret_go,
   input wire logic core_sleeping,
   input wire logic irq_vector,
   input wire logic ctx_restore,
   input wire eicu_pkg::eicu_ctx_t restore_ctx,
   output logic instr_done,
   output logic irq_return,
   output logic [12:0] return_pc,
   output eicu_pkg::eicu_ctx_t live_ctx
);
   import eicu_pkg::*;
   int n_vec;
   eicu_ctx_t saved_ctx;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         instr_done <= 1'b0;
         irq_return <= 1'b0;
         return_pc <= 13'h0100;
         live_ctx <= '0;
         n_vec <= 0;
         saved_ctx <= '0;
      end else begin
         // retire every other cycle, none while asleep
         instr_done <= run && !core_sleeping && !instr_done;
         irq_return <= ret_go;
         if (instr_done) begin
            return_pc <= return_pc + 13'h0001;
            live_ctx <= {live_ctx[55:0], live_ctx[63:56] + 8'h5b};
         end
         if (irq_vector) begin
            n_vec <= n_vec + 1;
            saved_ctx <= live_ctx;
            return_pc <= 13'h0004;
         end
         if (ctx_restore) begin
            live_ctx <= restore_ctx;
         end
      end
   end
endmodule // eicu_core_model

// ==== eicu_top_tb.sv ====
// self-checking testbench of the edge interrupt context unit
`timescale 1ns/1ps
`include "eicu_regs.svh"
module eicu_top_tb;
   import eicu_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ext_pin = 1'b0;
   logic [5:0] port_pin_n = 6'h00;
   logic core_sleeping = 1'b0;
   logic run = 1'b0;
   logic ret_go = 1'b0;
   eicu_bus_req_t bus_req = '0;
   logic [7:0] bus_rdata;
   logic wake_req, irq_vector, stack_push, instr_done, irq_return, ctx_restore;
   logic [12:0] return_pc, stack_pc;
   eicu_ctx_t live_ctx, restore_ctx, exp;
   int n_errors = 0;
   int checks_done = 0;
   eicu_top dut_u (.core_clk, .rst_b, .bus_req, .bus_rdata, .ext_pin, .port_pin_n,
      .core_sleeping, .instr_done, .irq_return, .return_pc, .live_ctx, .wake_req,
      .irq_vector, .stack_push, .stack_pc, .ctx_restore, .restore_ctx);
   eicu_core_model core_u (.core_clk, .rst_b, .run, .ret_go, .core_sleeping,
      .irq_vector, .ctx_restore, .restore_ctx, .instr_done, .irq_return,
      .return_pc, .live_ctx);
   initial forever #50 core_clk = ~core_clk;
   // ============================================================
   // access tasks
   task tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] want);
      checks_done++;
      if (got !== want) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
   endtask
   task rc(input logic [11:0] a, input logic [7:0] want);
      @(posedge core_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      @(negedge core_clk);
      chk({56'h0, bus_rdata}, {56'h0, want});
   endtask
   // pins settle through the two-flop synchroniser before the flag is looked at
   task pins(input logic e, input logic [5:0] p);
      @(posedge core_clk);
      ext_pin <= e;
      port_pin_n <= p;
      repeat (4) @(negedge core_clk);
   endtask
   task wait_vec(input int n);
      int i;
      for (i = 0; i < 40 && core_u.n_vec != n; i++) @(negedge core_clk);
      if (core_u.n_vec != n) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   // ============================================================
   // scenarios
   initial begin
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      rc(`EICU_OFS_CTRL, `EICU_RST_CTRL);
      rc(`EICU_OFS_OPT, `EICU_RST_OPT);
      rc(`EICU_OFS_FLAGS, 8'h00);
      wr(12'h010, 8'hff);
      rc(12'h010, 8'h00);
      wr(`EICU_OFS_RISE, 8'hff);
      rc(`EICU_OFS_RISE, 8'h3f);
      wr(`EICU_OFS_RISE, 8'h05);
      wr(`EICU_OFS_FALL, 8'h06);
      rc(`EICU_OFS_FALL, 8'h06);
      pins(1'b0, 6'h0f);
      rc(`EICU_OFS_FLAGS, 8'h05);
      wr(`EICU_OFS_FLAGS, 8'h01);
      rc(`EICU_OFS_FLAGS, 8'h01);
      pins(1'b0, 6'h00);
      rc(`EICU_OFS_FLAGS, 8'h07);
      wr(`EICU_OFS_FLAGS, 8'h00);
      rc(`EICU_OFS_FLAGS, 8'h00);
      wr(`EICU_OFS_CTRL, 8'h10);
      pins(1'b1, 6'h00);
      rc(`EICU_OFS_CTRL, 8'h12);
      wr(`EICU_OFS_CTRL, 8'h10);
      pins(1'b0, 6'h00);
      rc(`EICU_OFS_CTRL, 8'h10);
      wr(`EICU_OFS_OPT, 8'h00);
      pins(1'b1, 6'h00);
      rc(`EICU_OFS_CTRL, 8'h10);
      pins(1'b0, 6'h00);
      rc(`EICU_OFS_CTRL, 8'h12);
      wr(`EICU_OFS_CTRL, 8'h82);
      run <= 1'b1;
      repeat (10) @(negedge core_clk);
      chk(core_u.n_vec, 1'b0);
      wr(`EICU_OFS_CTRL, 8'h92);
      wait_vec(1);
      rc(`EICU_OFS_CTRL, 8'h12);
      @(posedge core_clk);
      run <= 1'b0;
      exp = core_u.saved_ctx;
      rc(`EICU_OFS_SHADOW, exp.w);
      rc(`EICU_OFS_SHADOW + 12'h1, exp.status & `EICU_STATUS_KEEP);
      rc(`EICU_OFS_SHADOW + 12'h7, exp.pc_high_latch);
      wr(`EICU_OFS_SHADOW, 8'ha5);
      rc(`EICU_OFS_SHADOW, 8'ha5);
      wr(`EICU_OFS_CTRL, 8'h10);
      exp.w = 8'ha5;
      exp.status = exp.status & `EICU_STATUS_KEEP;
      @(posedge core_clk);
      ret_go <= 1'b1;
      @(posedge core_clk);
      ret_go <= 1'b0;
      repeat (3) @(negedge core_clk);
      chk(core_u.live_ctx, exp);
      rc(`EICU_OFS_CTRL, 8'h90);
      wr(`EICU_OFS_CTRL, 8'h10);
      @(posedge core_clk);
      core_sleeping <= 1'b1;
      pins(1'b1, 6'h00);
      pins(1'b0, 6'h00);
      chk(wake_req, 1'b1);
      @(posedge core_clk);
      core_sleeping <= 1'b0;
      run <= 1'b1;
      repeat (10) @(negedge core_clk);
      chk(core_u.n_vec, 1);
      wr(`EICU_OFS_CTRL, 8'h10);
      run <= 1'b0;
      wr(`EICU_OFS_CTRL, 8'h90);
      @(posedge core_clk);
      core_sleeping <= 1'b1;
      pins(1'b1, 6'h00);
      pins(1'b0, 6'h00);
      chk(core_u.n_vec, 1);
      @(posedge core_clk);
      core_sleeping <= 1'b0;
      run <= 1'b1;
      wait_vec(2);
      wr(`EICU_OFS_CTRL, 8'h08);
      @(posedge core_clk);
      ret_go <= 1'b1;
      @(posedge core_clk);
      ret_go <= 1'b0;
      repeat (3) @(negedge core_clk);
      rc(`EICU_OFS_CTRL, 8'h88);
      pins(1'b0, 6'h01);
      rc(`EICU_OFS_FLAGS, 8'h01);
      wait_vec(3);
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      rc(`EICU_OFS_CTRL, `EICU_RST_CTRL);
      rc(`EICU_OFS_SHADOW, 8'h00);
      tally_and_finish();
   end
endmodule // eicu_top_tb
